// File: verilog/sbp_pkg.sv
// Package of constants and types for the sector block-protect decoder.
`default_nettype none
package sbp_pkg;
   // ----------------------------------------------------------------
   // Array densities and encodings
   // ----------------------------------------------------------------
   localparam int          SECTOR_W       = 10;
   localparam logic [3:0]  LEVEL_NONE     = 4'h0;
   localparam logic [3:0]  MAX_LEVEL_256  = 4'h8;
   localparam logic [3:0]  MAX_LEVEL_512  = 4'h9;
   localparam logic [3:0]  MAX_LEVEL_1024 = 4'hA;
   localparam logic        FLAG_RESET     = 1'b0;
   // Last sector of each supported array; every array starts at sector zero.
   localparam logic [SECTOR_W-1:0] LAST_SECTOR_256  = 10'h0FF;
   localparam logic [SECTOR_W-1:0] LAST_SECTOR_512  = 10'h1FF;
   localparam logic [SECTOR_W-1:0] LAST_SECTOR_1024 = 10'h3FF;

   typedef enum logic [1:0] {
      SBP_DENS_256,
      SBP_DENS_512,
      SBP_DENS_1024
   } sbp_density_type;
endpackage : sbp_pkg
`default_nettype wire

// File: verilog/sbp_decode.sv
// Sector block-protect decoder with request gating and protection error flag.
`default_nettype none
// Function
// - Range comes only from density, level and select.
// - Level zero protects nothing at all.
// - 256 sectors, select clear: top 2^(n-1).
// - 256 sectors, select set: bottom 2^(n-1).
// - 512 sectors, select clear: top 2^(n-1).
// - 512 sectors, select set: bottom 2^(n-1).
// - 1024 sectors, select clear: top 2^(n-1).
// - 1024 sectors, select set: bottom 2^(n-1).
// - Protected program or erase sets error flag.
module sbp_decode (
   input  wire logic                            CLK,
   input  wire logic                            RSTN,
   input  wire sbp_pkg::sbp_density_type        DENSITY,
   input  wire logic                            PROTECT_LEVEL_BIT0,
   input  wire logic                            PROTECT_LEVEL_BIT1,
   input  wire logic                            PROTECT_LEVEL_BIT2,
   input  wire logic                            PROTECT_LEVEL_BIT3,
   input  wire logic                            TOP_BOTTOM_SELECT,
   input  wire logic                            REQ_VALID,
   input  wire logic                            REQ_ERASE,
   input  wire logic [sbp_pkg::SECTOR_W-1:0]    REQ_SECTOR,
   input  wire logic                            FLAG_CLEAR,
   output logic                                 REQ_GRANT,
   output logic                                 REQ_BLOCKED,
   output logic                                 PROTECT_ERROR,
   output logic                                 ERASE_ERROR,
   output logic                                 WRITE_ERROR,
   output logic [sbp_pkg::SECTOR_W-1:0]         PROT_FIRST,
   output logic [sbp_pkg::SECTOR_W-1:0]         PROT_LAST,
   output logic                                 PROT_ANY
);
   // ----------------------------------------------------------------
   // Range decode
   // ----------------------------------------------------------------
   // The whole range derives from the density, level code and select bit only.
   logic [3:0]                  level;
   logic [3:0]                  max_level;
   logic [sbp_pkg::SECTOR_W-1:0] last_sector;
   logic [sbp_pkg::SECTOR_W:0]   span;
   logic                        all_prot;
   logic [sbp_pkg::SECTOR_W-1:0] lo_w;
   logic [sbp_pkg::SECTOR_W-1:0] hi_w;
   logic                        any_w;

   assign level = {PROTECT_LEVEL_BIT3, PROTECT_LEVEL_BIT2, PROTECT_LEVEL_BIT1, PROTECT_LEVEL_BIT0};

   // Density selects the highest graded level and the last sector.
   assign max_level   = (DENSITY == sbp_pkg::SBP_DENS_1024) ? sbp_pkg::MAX_LEVEL_1024 :
                        (DENSITY == sbp_pkg::SBP_DENS_512)  ? sbp_pkg::MAX_LEVEL_512  :
                                                              sbp_pkg::MAX_LEVEL_256;
   // The unused density code falls back to the smallest array, so sectors above 10'h0FF are never blocked.
   assign last_sector = (DENSITY == sbp_pkg::SBP_DENS_1024) ? sbp_pkg::LAST_SECTOR_1024 :
                        (DENSITY == sbp_pkg::SBP_DENS_512)  ? sbp_pkg::LAST_SECTOR_512  :
                                                              sbp_pkg::LAST_SECTOR_256;
   assign all_prot    = (level > max_level);
   // Span is 2^(n-1) sectors; always computed, but meaningful only when level is non-zero.
   assign span        = 11'(11'h001 << (level - 4'h1));

   // Top range ends at the last sector, bottom range starts at sector 0.
   assign any_w = (level != sbp_pkg::LEVEL_NONE);
   assign lo_w  = (all_prot || TOP_BOTTOM_SELECT) ? 10'h000 :
                  10'(last_sector - span[9:0] + 10'h001);
   assign hi_w  = (all_prot || !TOP_BOTTOM_SELECT) ? last_sector :
                  10'(span - 11'h001);

   assign PROT_ANY   = any_w;
   assign PROT_FIRST = lo_w;
   assign PROT_LAST  = hi_w;

   // ----------------------------------------------------------------
   // Request gating
   // ----------------------------------------------------------------
   // A refused request never reaches the array; it only raises flags.
   // The host must have loaded the status bits with write enable first.
   logic hit;
   assign hit         = any_w && (REQ_SECTOR >= lo_w) && (REQ_SECTOR <= hi_w) &&
                        (REQ_SECTOR <= last_sector);
   assign REQ_BLOCKED = REQ_VALID && hit;
   assign REQ_GRANT   = REQ_VALID && !hit;

   // ----------------------------------------------------------------
   // Sticky error flags
   // ----------------------------------------------------------------
   // A new violation in the clearing cycle wins, so no event is lost.
   logic prot_r;
   logic erase_r;
   logic write_r;
   logic prot_nxt;
   logic erase_nxt;
   logic write_nxt;
   assign prot_nxt  = REQ_BLOCKED || (prot_r && !FLAG_CLEAR);
   assign erase_nxt = (REQ_BLOCKED && REQ_ERASE) || (erase_r && !FLAG_CLEAR);
   assign write_nxt = (REQ_BLOCKED && !REQ_ERASE) || (write_r && !FLAG_CLEAR);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         prot_r  <= sbp_pkg::FLAG_RESET;
         erase_r <= sbp_pkg::FLAG_RESET;
         write_r <= sbp_pkg::FLAG_RESET;
      end else begin
         prot_r  <= prot_nxt;
         erase_r <= erase_nxt;
         write_r <= write_nxt;
      end
   end

   assign PROTECT_ERROR = prot_r;
   assign ERASE_ERROR   = erase_r;
   assign WRITE_ERROR   = write_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Range checks use their own arithmetic, so a slip in the shared decode shows up here.
   property p_level_zero;
      @(posedge CLK) disable iff (!RSTN) (level == 4'h0) |-> (!PROT_ANY && REQ_GRANT == REQ_VALID);
   endproperty
   a_level_zero: assert property (p_level_zero) else $error("Level zero protected a sector.");

   property p_top_256;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_256 && !TOP_BOTTOM_SELECT && level >= 4'h1 && level <= 4'h8)
         |-> (PROT_LAST == 10'h0FF && PROT_FIRST == 10'(11'h100 - (11'h001 << (level - 4'h1))));
   endproperty
   a_top_256: assert property (p_top_256) else $error("Top range wrong for 256 sectors.");

   property p_bot_256;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_256 && TOP_BOTTOM_SELECT && level >= 4'h1 && level <= 4'h8)
         |-> (PROT_FIRST == 10'h000 && PROT_LAST == 10'((11'h001 << (level - 4'h1)) - 11'h001));
   endproperty
   a_bot_256: assert property (p_bot_256) else $error("Bottom range wrong for 256 sectors.");

   property p_top_512;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_512 && !TOP_BOTTOM_SELECT && level >= 4'h1 && level <= 4'h9)
         |-> (PROT_LAST == 10'h1FF && PROT_FIRST == 10'(11'h200 - (11'h001 << (level - 4'h1))));
   endproperty
   a_top_512: assert property (p_top_512) else $error("Top range wrong for 512 sectors.");

   property p_bot_512;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_512 && TOP_BOTTOM_SELECT && level >= 4'h1)
         |-> (PROT_FIRST == 10'h000 &&
              PROT_LAST == ((level >= 4'hA) ? 10'h1FF : 10'((11'h001 << (level - 4'h1)) - 11'h001)));
   endproperty
   a_bot_512: assert property (p_bot_512) else $error("Bottom range wrong for 512 sectors.");

   property p_top_1024;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_1024 && !TOP_BOTTOM_SELECT && level >= 4'h1 && level <= 4'hA)
         |-> (PROT_LAST == 10'h3FF && PROT_FIRST == 10'(11'h400 - (11'h001 << (level - 4'h1))));
   endproperty
   a_top_1024: assert property (p_top_1024) else $error("Top range wrong for 1024 sectors.");

   property p_bot_1024;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_1024 && TOP_BOTTOM_SELECT && level >= 4'h1 && level <= 4'hA)
         |-> (PROT_FIRST == 10'h000 && PROT_LAST == 10'((11'h001 << (level - 4'h1)) - 11'h001));
   endproperty
   a_bot_1024: assert property (p_bot_1024) else $error("Bottom range wrong for 1024 sectors.");

   property p_flag_set;
      @(posedge CLK) disable iff (!RSTN) REQ_BLOCKED |=> PROTECT_ERROR;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("Blocked request did not set the flag.");

   // End sectors are checked without the shared comparator, so a broken compare is caught.
   property p_no_grant;
      @(posedge CLK) disable iff (!RSTN)
         (REQ_VALID && level != 4'h0 &&
          (TOP_BOTTOM_SELECT ? (REQ_SECTOR == 10'h000) : (REQ_SECTOR == last_sector)))
         |-> (REQ_BLOCKED && !REQ_GRANT);
   endproperty
   a_no_grant: assert property (p_no_grant) else $error("Protected sector was granted.");

   property p_flag_hold;
      @(posedge CLK) disable iff (!RSTN) (PROTECT_ERROR && !FLAG_CLEAR) |=> PROTECT_ERROR;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Protection flag dropped unasked.");

   // Levels past the graded ones lock the whole array, whichever end is selected.
   property p_full_256;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_256 && level >= 4'h9)
         |-> (PROT_ANY && PROT_FIRST == 10'h000 && PROT_LAST == 10'h0FF);
   endproperty
   a_full_256: assert property (p_full_256) else $error("Full range wrong for 256 sectors.");

   property p_full_1024;
      @(posedge CLK) disable iff (!RSTN)
         (DENSITY == sbp_pkg::SBP_DENS_1024 && level >= 4'hB)
         |-> (PROT_ANY && PROT_FIRST == 10'h000 && PROT_LAST == 10'h3FF);
   endproperty
   a_full_1024: assert property (p_full_1024) else $error("Full range wrong for 1024 sectors.");

   // Each kind of refused request leaves its own mark one cycle later.
   property p_erase_flag;
      @(posedge CLK) disable iff (!RSTN) (REQ_BLOCKED && REQ_ERASE) |=> ERASE_ERROR;
   endproperty
   a_erase_flag: assert property (p_erase_flag) else $error("Blocked erase did not set its flag.");

   property p_write_flag;
      @(posedge CLK) disable iff (!RSTN) (REQ_BLOCKED && !REQ_ERASE) |=> WRITE_ERROR;
   endproperty
   a_write_flag: assert property (p_write_flag) else $error("Blocked write did not set its flag.");

   // A clear with no new violation in the same cycle empties all three flags.
   property p_flag_clear;
      @(posedge CLK) disable iff (!RSTN)
         (FLAG_CLEAR && !REQ_BLOCKED) |=> (!PROTECT_ERROR && !ERASE_ERROR && !WRITE_ERROR);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("Flag clear left a flag standing.");

   // Covers mark the scenarios that the bench is meant to reach.
   c_blocked_erase: cover property (@(posedge CLK) disable iff (!RSTN) REQ_BLOCKED && REQ_ERASE);
   c_blocked_write: cover property (@(posedge CLK) disable iff (!RSTN) REQ_BLOCKED && !REQ_ERASE);
   c_all_prot:      cover property (@(posedge CLK) disable iff (!RSTN) all_prot && REQ_VALID);
   c_clear_set:     cover property (@(posedge CLK) disable iff (!RSTN) FLAG_CLEAR && REQ_BLOCKED);
   c_clear_only:    cover property (@(posedge CLK) disable iff (!RSTN) FLAG_CLEAR && PROTECT_ERROR && !REQ_BLOCKED);
endmodule : sbp_decode
`default_nettype wire

// File: dv/sbp_host.sv
// Host-side model that loads the protection setting into the device.
`default_nettype none
module sbp_host (
   input  wire logic       CLK,
   input  wire logic       RSTN,
   input  wire logic       WEN,
   input  wire logic       WSTAT,
   input  wire logic [4:0] SDATA,
   output logic            TOP_BOTTOM_SELECT,
   output logic            PROTECT_LEVEL_BIT3,
   output logic            PROTECT_LEVEL_BIT2,
   output logic            PROTECT_LEVEL_BIT1,
   output logic            PROTECT_LEVEL_BIT0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] stat_r;
   logic       wel_r;
   // Status bits as seen by the decoder.
   assign {TOP_BOTTOM_SELECT, PROTECT_LEVEL_BIT3, PROTECT_LEVEL_BIT2, PROTECT_LEVEL_BIT1, PROTECT_LEVEL_BIT0} = stat_r;
   // A status write without a prior write enable is dropped, so the bench must send both.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wel_r  <= 1'b0;
         stat_r <= 5'h00;
      end else begin
         wel_r <= WEN || (wel_r && !WSTAT);
         if (WSTAT && wel_r) stat_r <= SDATA;
      end
   end
endmodule : sbp_host
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the sector block-protect decoder.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0, RSTN = 1'b0, WEN = 1'b0, WSTAT = 1'b0, REQ_VALID = 1'b0, REQ_ERASE = 1'b0, FLAG_CLEAR = 1'b0;
   logic TOP_BOTTOM_SELECT, PROTECT_LEVEL_BIT3, PROTECT_LEVEL_BIT2, PROTECT_LEVEL_BIT1, PROTECT_LEVEL_BIT0;
   logic REQ_GRANT, REQ_BLOCKED, PROTECT_ERROR, ERASE_ERROR, WRITE_ERROR, PROT_ANY, ea, eb, xp, xe, xw;
   logic [4:0] SDATA = 5'h00;
   logic [9:0] REQ_SECTOR = 10'h000, PROT_FIRST, PROT_LAST, ef, el;
   logic [15:0] rnd = 16'h0050;
   int fail_count = 0, samples_checked = 0;
   sbp_pkg::sbp_density_type DENSITY = sbp_pkg::SBP_DENS_256;
   sbp_host sbp_host_i (
      .CLK                (CLK),
      .RSTN               (RSTN),
      .WEN                (WEN),
      .WSTAT              (WSTAT),
      .SDATA              (SDATA),
      .TOP_BOTTOM_SELECT  (TOP_BOTTOM_SELECT),
      .PROTECT_LEVEL_BIT3 (PROTECT_LEVEL_BIT3),
      .PROTECT_LEVEL_BIT2 (PROTECT_LEVEL_BIT2),
      .PROTECT_LEVEL_BIT1 (PROTECT_LEVEL_BIT1),
      .PROTECT_LEVEL_BIT0 (PROTECT_LEVEL_BIT0)
   );
   sbp_decode sbp_decode_i (
      .CLK                (CLK),
      .RSTN               (RSTN),
      .DENSITY            (DENSITY),
      .PROTECT_LEVEL_BIT0 (PROTECT_LEVEL_BIT0),
      .PROTECT_LEVEL_BIT1 (PROTECT_LEVEL_BIT1),
      .PROTECT_LEVEL_BIT2 (PROTECT_LEVEL_BIT2),
      .PROTECT_LEVEL_BIT3 (PROTECT_LEVEL_BIT3),
      .TOP_BOTTOM_SELECT  (TOP_BOTTOM_SELECT),
      .REQ_VALID          (REQ_VALID),
      .REQ_ERASE          (REQ_ERASE),
      .REQ_SECTOR         (REQ_SECTOR),
      .FLAG_CLEAR         (FLAG_CLEAR),
      .REQ_GRANT          (REQ_GRANT),
      .REQ_BLOCKED        (REQ_BLOCKED),
      .PROTECT_ERROR      (PROTECT_ERROR),
      .ERASE_ERROR        (ERASE_ERROR),
      .WRITE_ERROR        (WRITE_ERROR),
      .PROT_FIRST         (PROT_FIRST),
      .PROT_LAST          (PROT_LAST),
      .PROT_ANY           (PROT_ANY)
   );
   // Free-running 100 MHz clock.
   initial forever #5 CLK = ~CLK;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   // Expected range; levels above the density's maximum cover the whole array.
   // The unused density code counts as the smallest array.
   function automatic void calc(input logic [3:0] n, input logic bot);
      int dn;
      dn = (DENSITY == sbp_pkg::SBP_DENS_512) ? 1 : (DENSITY == sbp_pkg::SBP_DENS_1024) ? 2 : 0;
      el = 10'((256 << dn) - 1);
      ef = 10'h000;
      ea = n != 4'h0;
      if (ea && n <= 4'(8 + dn) && bot) el = 10'((1 << (n - 1)) - 1);
      if (ea && n <= 4'(8 + dn) && !bot) ef = 10'(el - (1 << (n - 1)) + 1);
   endfunction : calc
   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // Inputs always change one time unit after the rising edge.
   task automatic step();
      @(posedge CLK);
      #1;
   endtask : step
   // Requests are held off while the setting changes, so flag expectations stay valid.
   task automatic set_prot(input logic [4:0] v);
      REQ_VALID = 1'b0;
      FLAG_CLEAR = 1'b0;
      WEN = 1'b1;
      step();
      WEN = 1'b0;
      WSTAT = 1'b1;
      SDATA = v;
      step();
      WSTAT = 1'b0;
      calc(v[3:0], v[4]);
   endtask : set_prot
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (4) step();
      RSTN = 1'b1;
      {xp, xe, xw} = 3'h0;
      // Every density, select value and level code.
      for (int d = 0; d < 4; d++) begin
         DENSITY = sbp_pkg::sbp_density_type'(d);
         for (int c = 0; c < 32; c++) begin
            set_prot(5'(c));
            chk({9'h000, PROT_ANY}, {9'h000, ea}, "any");
            if (ea) chk(PROT_FIRST, ef, "first");
            if (ea) chk(PROT_LAST, el, "last");
         end
      end
      $display("range sweep done");
      // Back-to-back requests at range edges and random sectors, with random flag clears.
      for (int i = 0; i < 600; i++) begin
         rnd = lfsr(rnd);
         if (i % 30 == 0) DENSITY = sbp_pkg::sbp_density_type'(rnd[6:5] % 2'h3);
         if (i % 30 == 0) set_prot(rnd[4:0]);
         REQ_VALID = rnd[7];
         REQ_ERASE = rnd[8];
         FLAG_CLEAR = rnd[11:9] == 3'h0;
         REQ_SECTOR = (i % 4 == 0) ? ef : (i % 4 == 1) ? el + 10'h001 : (i % 4 == 2) ? ef - 10'h001 : rnd[15:6];
         #1;
         eb = REQ_VALID && ea && REQ_SECTOR >= ef && REQ_SECTOR <= el;
         chk({9'h000, REQ_BLOCKED}, {9'h000, eb}, "blocked");
         chk({9'h000, REQ_GRANT}, {9'h000, REQ_VALID && !eb}, "grant");
         xp = eb | (xp & !FLAG_CLEAR);
         xe = (eb & REQ_ERASE) | (xe & !FLAG_CLEAR);
         xw = (eb & !REQ_ERASE) | (xw & !FLAG_CLEAR);
         step();
         chk({7'h00, PROTECT_ERROR, ERASE_ERROR, WRITE_ERROR}, {7'h00, xp, xe, xw}, "flags");
      end
      $display("request test done");
      // Mid-run reset with flags up, then a request in the very first cycle after release.
      set_prot(5'h01);
      REQ_VALID = 1'b1;
      REQ_ERASE = 1'b1;
      REQ_SECTOR = el;
      xp = 1'b1;
      xe = 1'b1;
      step();
      REQ_VALID = 1'b0;
      chk({7'h00, PROTECT_ERROR, ERASE_ERROR, WRITE_ERROR}, {7'h00, xp, xe, xw}, "flags before reset");
      RSTN = 1'b0;
      step();
      RSTN = 1'b1;
      chk({7'h00, PROTECT_ERROR, ERASE_ERROR, WRITE_ERROR}, 10'h000, "flags after reset");
      chk({9'h000, PROT_ANY}, 10'h000, "any after reset");
      REQ_VALID = 1'b1;
      REQ_SECTOR = 10'h000;
      #1;
      chk({9'h000, REQ_GRANT}, 10'h001, "grant after reset");
      step();
      REQ_VALID = 1'b0;
      chk({7'h00, PROTECT_ERROR, ERASE_ERROR, WRITE_ERROR}, 10'h000, "flags after release");
      $display("reset test done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
